// file: logic/astm_defs.vh
// Purpose: constants of the converter serial sequencer
// Assumes: 100 MHz system clock
// Notes:   times in ns, cycle counts derived from them
`ifndef ASTM_DEFS_VH
`define ASTM_DEFS_VH

`define ASTM_CLK_NS          10
`define ASTM_EOCTEST_NS      12000
// least time, so round up to whole cycles
`define ASTM_EOCTEST_CYC     ((`ASTM_EOCTEST_NS + `ASTM_CLK_NS - 1) / `ASTM_CLK_NS)
// 3.6 oscillator periods, rounded up to whole periods
`define ASTM_EXT_OSC_EDGES   4
`define ASTM_WORD_BITS       24
`define ASTM_RES_BITS        22
`define ASTM_CHAN_BITS       5
`define ASTM_IN_BITS         8
`define ASTM_CHAN_LOAD_EDGE  8
`define ASTM_LAST_EDGE       24
`define ASTM_CHAN_RESET      5'h00
`define ASTM_PREFIX_LOAD     3'h5
`define ASTM_SCK_HALF        4
`define ASTM_FIFO_DEPTH      8

`endif

// file: logic/astm_sync.v
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs asynchronous to clk_sys
// Notes:   first stage feeds only the second stage
`default_nettype none

module astm_sync #(
    parameter W = 1
) (
    input  wire         clk_sys,
    input  wire         nrst,
    input  wire         ce,
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);

reg [W-1:0] meta;

always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
        meta <= {W{1'b0}};
        q    <= {W{1'b0}};
    end else if (ce) begin
        meta <= d;
        q    <= meta;
    end
end

endmodule

`default_nettype wire

// file: logic/astm_fifo.v
// Purpose: result buffer between converter core and serial port
// Assumes: same clock on both sides
// Notes:   in_ready is registered so it never glitches
`default_nettype none

module astm_fifo #(
    parameter WIDTH = 22,
    parameter DEPTH = 8
) (
    input  wire             clk_sys,
    input  wire             nrst,
    input  wire             ce,
    input  wire             in_valid,
    output reg              in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);

localparam AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW-1:0]    wr_ptr;
reg [AW-1:0]    rd_ptr;
reg [AW:0]      count;
wire            push;
wire            pop;
wire [AW:0]     next_count;

assign push       = in_valid & in_ready;
assign pop        = out_valid & out_ready;
assign out_valid  = (count != {(AW+1){1'b0}});
assign out_data   = mem[rd_ptr];
assign next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

always @(posedge clk_sys) begin
    if (ce && push) begin
        mem[wr_ptr] <= in_data;
    end
end

always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
        wr_ptr   <= {AW{1'b0}};
        rd_ptr   <= {AW{1'b0}};
        count    <= {(AW+1){1'b0}};
        in_ready <= 1'b0;
    end else if (ce) begin
        if (push) begin
            wr_ptr <= (wr_ptr == DEPTH - 1) ? {AW{1'b0}} : wr_ptr + 1'b1;
        end
        if (pop) begin
            rd_ptr <= (rd_ptr == DEPTH - 1) ? {AW{1'b0}} : rd_ptr + 1'b1;
        end
        count    <= next_count;
        in_ready <= (next_count != DEPTH[AW:0]);
    end
end

endmodule

`default_nettype wire

// file: logic/astm_top.v
// Purpose: serial timing sequencer of a multi-channel converter
// Assumes: converter core pushes finished results into res_*
// Notes:   all pins pass astm_sync before use
// Notes on behaviour
// - low SCK at select fall picks external clock
// - data output off while select high, else status
// - status one converting, zero when asleep
// - sleep at completion until first SCK rise
// - sample input on rise, shift output on fall
// - external clock: 24th fall starts conversion
// - new channel applies to the following conversion
// - external abort by select rise starts conversion
// - channel loads only after eight falling edges
// - mode latched from SCK at power-on end
// - three-wire: result loaded when status falls
// - weak pull-up on SCK during select fall
// - internal clock: first rise after check window
// - internal: 24th rise starts conversion, SCK high
// - internal abort by select rise starts conversion
// - continuous: both low, half period, then shift
// - continuous: after 24th rise convert, repeat
// - status stays on output after exchange
// - prefix 101 loads channel, 000/100 keep it
// - select bit chooses differential or common input
// - power-up: channel 0/1 differential, convert
`default_nettype none
`include "astm_defs.vh"

module astm_top #(
    parameter SCK_HALF   = `ASTM_SCK_HALF,
    parameter EOCTEST    = `ASTM_EOCTEST_CYC,
    parameter FIFO_DEPTH = `ASTM_FIFO_DEPTH
) (
    input  wire                       clk_sys,
    input  wire                       nrst,
    input  wire                       ce,
    input  wire                       por_done,
    input  wire                       cs_n_pin,
    input  wire                       sck_in,
    output reg                        sck_out,
    output reg                        sck_oe_n,
    output reg                        sck_pullup_en,
    input  wire                       sdi_pin,
    output reg                        sdo_out,
    output reg                        sdo_oe_n,
    input  wire                       oscillator_source_pin,
    input  wire                       res_valid,
    output wire                       res_ready,
    input  wire [`ASTM_RES_BITS-1:0]  res_data,
    output reg                        conv_start,
    output reg                        conv_busy,
    output reg  [`ASTM_CHAN_BITS-1:0] chan_sel,
    output reg                        int_clk_mode
);

localparam ST_CONV  = 2'd0;
localparam ST_SLEEP = 2'd1;
localparam ST_WAIT  = 2'd2;
localparam ST_XFER  = 2'd3;

////////////////////////////////////////////////////////////////////////////
// pin synchronisers and edge detect

wire [2:0] pins_s;
wire       cs_s;
wire       sck_s;
wire       sdi_s;
wire       osc_s;

// select is synced inverted so that its reset level is the idle high level
astm_sync #(.W(3)) u_sync (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .ce      (ce),
    .d       ({~cs_n_pin, sck_in, sdi_pin}),
    .q       (pins_s)
);

astm_sync #(.W(1)) u_sync_osc (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .ce      (ce),
    .d       (oscillator_source_pin),
    .q       (osc_s)
);

assign cs_s  = ~pins_s[2];
assign sck_s = pins_s[1];
assign sdi_s = pins_s[0];

reg                       cs_q;
reg                       sck_q;
reg                       osc_q;
reg                       por_q;
reg [1:0]                 state;
reg [`ASTM_WORD_BITS-1:0] shift_out;
reg [`ASTM_IN_BITS-1:0]   shift_in;
reg [`ASTM_IN_BITS-1:0]   pend_word;
reg                       pend_ok;
reg [4:0]                 rise_cnt;
reg [4:0]                 fall_cnt;
reg [15:0]                hcnt;
reg [15:0]                tcnt;
reg [2:0]                 osc_cnt;
reg                       osc_seen;
reg                       wait_long;

wire cs_fall = cs_q & ~cs_s;
wire cs_rise = ~cs_q & cs_s;

////////////////////////////////////////////////////////////////////////////
// result buffer; completion of a conversion is the arrival of a word

wire                      fifo_valid;
wire [`ASTM_RES_BITS-1:0] fifo_data;
wire                      conv_done;

assign conv_done = (state == ST_CONV) & conv_busy & fifo_valid;

astm_fifo #(.WIDTH(`ASTM_RES_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .ce        (ce),
    .in_valid  (res_valid),
    .in_ready  (res_ready),
    .in_data   (res_data),
    .out_valid (fifo_valid),
    .out_ready (conv_done),
    .out_data  (fifo_data)
);

////////////////////////////////////////////////////////////////////////////
// serial clock events, from the pin or from the internal divider

wire int_tick = int_clk_mode & (state == ST_XFER)
              & (hcnt == SCK_HALF - 1);
wire ext_rise = ~int_clk_mode & ~cs_s & sck_s & ~sck_q;
wire ext_fall = ~int_clk_mode & ~cs_s & ~sck_s & sck_q;
wire rise_ev  = int_clk_mode ? (int_tick & ~sck_out) : ext_rise;
wire fall_ev  = int_clk_mode ? (int_tick & sck_out) : ext_fall;

// the check window uses the external oscillator once one is seen toggling
wire wait_done = wait_long
    ? (osc_seen ? (osc_cnt >= `ASTM_EXT_OSC_EDGES)
                : (tcnt >= EOCTEST - 1))
    : (tcnt >= SCK_HALF - 1);

// a started exchange may be aborted; before the first fall (external) or rise (internal) it is only a check
wire abort_ok = int_clk_mode ? (rise_cnt != 5'd0)
                             : (fall_cnt != 5'd0);

wire [4:0] rise_nxt = rise_cnt + 5'd1;
wire [4:0] fall_nxt = fall_cnt + 5'd1;

////////////////////////////////////////////////////////////////////////////
// sequencer

task start_conv;
    begin
        state      <= ST_CONV;
        conv_start <= 1'b1;
        conv_busy  <= 1'b1;
        sdo_out    <= 1'b1;
        sck_out    <= 1'b1;
        rise_cnt   <= 5'd0;
        fall_cnt   <= 5'd0;
        pend_ok    <= 1'b0;
        // selection taken during the exchange takes effect now only
        if (pend_ok &&
            pend_word[7:5] == `ASTM_PREFIX_LOAD) begin
            chan_sel <= pend_word[4:0];
        end
    end
endtask

always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
        cs_q          <= 1'b1;
        sck_q         <= 1'b0;
        osc_q         <= 1'b0;
        por_q         <= 1'b0;
        state         <= ST_CONV;
        shift_out     <= 24'h00_0000;
        shift_in      <= 8'h00;
        pend_word     <= 8'h00;
        pend_ok       <= 1'b0;
        rise_cnt      <= 5'd0;
        fall_cnt      <= 5'd0;
        hcnt          <= 16'h0000;
        tcnt          <= 16'h0000;
        osc_cnt       <= 3'd0;
        osc_seen      <= 1'b0;
        wait_long     <= 1'b0;
        sck_out       <= 1'b0;
        sck_oe_n      <= 1'b1;
        sck_pullup_en <= 1'b1;
        sdo_out       <= 1'b1;
        sdo_oe_n      <= 1'b1;
        conv_start    <= 1'b0;
        conv_busy     <= 1'b0;
        chan_sel      <= `ASTM_CHAN_RESET;
        int_clk_mode  <= 1'b1;
    end else if (ce) begin
        cs_q       <= cs_s;
        sck_q      <= sck_s;
        osc_q      <= osc_s;
        por_q      <= por_done;
        conv_start <= 1'b0;
        // pull-up only while nobody should be driving the clock low
        sck_pullup_en <= ~por_done | cs_s;
        sdo_oe_n <= cs_s;
        // the internal clock is only driven while select is low; not in
        // the cycle that relatches the mode, nor before power-on is seen
        sck_oe_n <= ~int_clk_mode | cs_s | cs_fall | ~por_q;
        if (osc_s && !osc_q) begin
            osc_seen <= 1'b1;
            if (osc_cnt != 3'd7) begin
                osc_cnt <= osc_cnt + 3'd1;
            end
        end
        hcnt <= (int_tick || state != ST_XFER) ? 16'h0000 : hcnt + 16'h0001;
        if (tcnt != 16'hffff) begin
            tcnt <= tcnt + 16'h0001;
        end

        if (por_done && !por_q) begin
            int_clk_mode <= sck_s;
            start_conv;
        end else if (por_done) begin
            if (cs_fall) begin
                int_clk_mode <= sck_s;
            end
            case (state)
            ST_CONV: begin
                sdo_out <= 1'b1;
                sck_out <= 1'b1;
                if (conv_done) begin
                    conv_busy <= 1'b0;
                    sdo_out   <= 1'b0;
                    // word 23 is status, 22 is a dummy zero
                    shift_out <= {2'b00, fifo_data};
                    sck_out   <= 1'b0;
                    tcnt      <= 16'h0000;
                    wait_long <= 1'b0;
                    state     <= (int_clk_mode && !cs_s)
                               ? ST_WAIT : ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                sdo_out <= 1'b0;
                sck_out <= 1'b0;
                if (cs_fall && sck_s) begin
                    // select fell with clock high: internal check
                    tcnt      <= 16'h0000;
                    osc_cnt   <= 3'd0;
                    wait_long <= 1'b1;
                    state     <= ST_WAIT;
                end else if (ext_rise && !cs_fall) begin
                    shift_in <= {shift_in[6:0], sdi_s};
                    rise_cnt <= 5'd1;
                    state    <= ST_XFER;
                end
            end
            ST_WAIT: begin
                sck_out <= 1'b0;
                if (cs_rise) begin
                    state <= ST_SLEEP;
                end else if (wait_done) begin
                    sck_out  <= 1'b1;
                    shift_in <= {shift_in[6:0], sdi_s};
                    rise_cnt <= 5'd1;
                    state    <= ST_XFER;
                end
            end
            ST_XFER: begin
                sdo_out <= shift_out[`ASTM_WORD_BITS-1];
                if (int_tick) begin
                    sck_out <= ~sck_out;
                end
                if (cs_rise) begin
                    if (abort_ok) begin
                        start_conv;
                    end else begin
                        state    <= ST_SLEEP;
                        rise_cnt <= 5'd0;
                    end
                end else if (rise_ev) begin
                    rise_cnt <= rise_nxt;
                    if (rise_cnt < `ASTM_IN_BITS) begin
                        shift_in <= {shift_in[6:0], sdi_s};
                    end
                    if (int_clk_mode &&
                        rise_nxt == `ASTM_LAST_EDGE) begin
                        start_conv;
                    end
                end else if (fall_ev) begin
                    fall_cnt  <= fall_nxt;
                    shift_out <= {shift_out[22:0], 1'b0};
                    sdo_out   <= shift_out[`ASTM_WORD_BITS-2];
                    if (fall_nxt == `ASTM_CHAN_LOAD_EDGE) begin
                        pend_word <= shift_in;
                        pend_ok   <= 1'b1;
                    end
                    if (!int_clk_mode &&
                        fall_nxt == `ASTM_LAST_EDGE) begin
                        start_conv;
                    end
                end
            end
            default: begin
                state <= ST_CONV;
            end
            endcase
        end
    end
end

endmodule

`default_nettype wire

// file: verif/astm_monitor.sv
// Purpose: pin-level checks on the serial sequencer
// Assumes: pins reach the block through a two-flop sync
// Notes:   three cycles of lag from a pin to its effect are allowed
`default_nettype none
module astm_monitor (
    input wire logic       clk_sys,
    input wire logic       nrst,
    input wire logic       por_done,
    input wire logic       cs_n_pin,
    input wire logic       sck_out,
    input wire logic       sck_oe_n,
    input wire logic       sck_pullup_en,
    input wire logic       sdo_out,
    input wire logic       sdo_oe_n,
    input wire logic       conv_start,
    input wire logic       conv_busy,
    input wire logic [4:0] chan_sel,
    input wire logic       int_clk_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
////////////////////////////////////////////////////////////////////////
    sdo_hiz_a: assert property (cs_n_pin [*4] |-> sdo_oe_n)
        else $error("data output driven while deselected");
    pullup_idle_a: assert property (
        cs_n_pin [*4] |-> sck_pullup_en)
        else $error("clock pull-up off while deselected");
    busy_on_start_a: assert property (
        conv_start |-> ##[0:1] conv_busy) else $error("start without busy");
    start_pulse_a: assert property (conv_start |=> !conv_start)
        else $error("start pulse longer than one cycle");
    chan_at_start_a: assert property (
        $changed(chan_sel) |-> conv_start || $past(conv_start))
        else $error("channel changed outside a conversion start");
    ext_no_drive_a: assert property (!int_clk_mode |-> sck_oe_n)
        else $error("clock driven in external clock mode");
    status_high_a: assert property (
        conv_start && !sdo_oe_n |-> ##[0:2] (sdo_out || sdo_oe_n))
        else $error("data output not high at conversion start");
    sck_low_wait_a: assert property (
        $fell(sck_oe_n) |-> ##1 !sck_out [*8])
        else $error("clock rose too soon after select");
    sck_held_a: assert property (
        conv_start && int_clk_mode && !sck_oe_n |-> sck_out)
        else $error("clock not high at internal conversion start");
    por_start_a: assert property (
        $rose(por_done) |=> conv_start && chan_sel == 5'h00)
        else $error("no default conversion after power-on");
    cover property (conv_start && !sdo_oe_n);
    cover property (!sck_oe_n && sck_out);
    cover property ($changed(chan_sel));
endmodule
////////////////////////////////////////////////////////////////////////
bind astm_top astm_monitor u_astm_monitor (
    .clk_sys(clk_sys), .nrst(nrst), .por_done(por_done),
    .cs_n_pin(cs_n_pin), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
    .sck_pullup_en(sck_pullup_en), .sdo_out(sdo_out),
    .sdo_oe_n(sdo_oe_n), .conv_start(conv_start),
    .conv_busy(conv_busy), .chan_sel(chan_sel),
    .int_clk_mode(int_clk_mode)
);
`default_nettype wire

// file: verif/astm_host.sv
// Purpose: host controller on the serial link
// Assumes: bench clock drives all pin changes
// Notes:   released lines show the inverse of their last level, but SCK reads high while its pull-up is on
`default_nettype none
module astm_host (
    input  wire logic clk_sys,
    input  wire logic sck_out,
    input  wire logic sck_oe_n,
    input  wire logic sck_pullup_en,
    input  wire logic sdo_out,
    input  wire logic sdo_oe_n,
    output logic      cs_n_pin,
    output logic      sck_in,
    output logic      sdi_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic host_sck = 1'b0;
    logic host_drv = 1'b1;
    logic last_sck = 1'b0;
    logic last_sdo = 1'b0;
    logic sdo_w;
    initial begin
        cs_n_pin = 1'b1;
        sdi_pin = 1'b0;
    end
    // host holds sck low from time zero, so power-on picks external
    assign sck_in = !sck_oe_n ? sck_out : host_drv ? host_sck
                  : sck_pullup_en ? 1'b1 : ~last_sck;
    assign sdo_w = !sdo_oe_n ? sdo_out : ~last_sdo;
    always @(posedge clk_sys) begin
        last_sck <= sck_in;
        last_sdo <= sdo_w;
    end
////////////////////////////////////////////////////////////////////////
    task automatic ext_xfer(input logic [7:0] din, input int nf,
                            output logic [23:0] dout);
        int i;
        dout = 24'h00_0000;
        cs_n_pin <= 1'b0; // sck low at this fall keeps external
        repeat (8) @(posedge clk_sys);
        for (i = 0; i < nf; i++) begin
            sdi_pin <= (i < 8) ? din[7 - i] : 1'b0;
            repeat (8) @(posedge clk_sys);
            dout = {dout[22:0], sdo_w};
            host_sck <= 1'b1;
            repeat (8) @(posedge clk_sys);
            host_sck <= 1'b0;
        end
        repeat (8) @(posedge clk_sys);
        cs_n_pin <= 1'b1; // short counts abort mid-word
        repeat (8) @(posedge clk_sys);
    endtask
    task automatic int_xfer(output logic [23:0] dout);
        dout = 24'h00_0000;
        host_drv <= 1'b0; // left floating, the pull-up picks internal
        sdi_pin <= 1'b0;
        repeat (4) @(posedge clk_sys);
        cs_n_pin <= 1'b0;
        repeat (24) begin
            while (sck_in !== 1'b0) @(posedge clk_sys);
            while (sck_in !== 1'b1) @(posedge clk_sys);
            // level held across the rise; the 24th rise also raises status
            dout = {dout[22:0], last_sdo};
        end
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic int_peek(input int hold);
        cs_n_pin <= 1'b0;
        repeat (hold) @(posedge clk_sys);
        cs_n_pin <= 1'b1; // up before the first rise keeps sleep
        repeat (8) @(posedge clk_sys);
    endtask
    task automatic deselect;
        cs_n_pin <= 1'b1;
    endtask
endmodule
`default_nettype wire

// file: verif/adc_serial_timing_modes_tb.sv
// Purpose: self-checking bench of the serial sequencer
// Assumes: results queue in the buffer before power-on ends
// Notes:   a full buffer makes the first eight conversions finish at once; the ninth stays busy
`default_nettype none
module adc_serial_timing_modes_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TIMEOUT = 20000;
    logic        clk_sys;
    logic        nrst;
    logic        por_done;
    logic        res_valid;
    logic [21:0] res_data;
    logic        cs_n_pin, sck_in, sdi_pin, sck_out, sck_oe_n;
    logic        sck_pullup_en, sdo_out, sdo_oe_n, res_ready;
    logic        conv_start, conv_busy, int_clk_mode;
    logic [4:0]  chan_sel;
    logic [21:0] rs [8];
    logic [21:0] v;
    logic [23:0] w;
    logic [7:0]  din [5] = '{8'hb1, 8'ha3, 8'hb2, 8'h85, 8'h1f};
    int          nf [5] = '{24, 5, 8, 24, 24};
    logic [4:0]  ch [5] = '{5'h11, 5'h11, 5'h12, 5'h12, 5'h12};
    int          i, k;
    int          starts = 0;
    int          cycles = 0;
    int          mismatches = 0;
    int          check_count = 0;
    astm_top #(.EOCTEST(20)) u_astm_top (
        .clk_sys(clk_sys), .nrst(nrst), .ce(1'b1), .por_done(por_done),
        .cs_n_pin(cs_n_pin), .sck_in(sck_in), .sck_out(sck_out),
        .sck_oe_n(sck_oe_n), .sck_pullup_en(sck_pullup_en),
        .sdi_pin(sdi_pin), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n),
        .oscillator_source_pin(1'b0), .res_valid(res_valid),
        .res_ready(res_ready), .res_data(res_data),
        .conv_start(conv_start), .conv_busy(conv_busy),
        .chan_sel(chan_sel), .int_clk_mode(int_clk_mode)
    );
    astm_host u_astm_host (
        .clk_sys(clk_sys), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
        .sck_pullup_en(sck_pullup_en), .sdo_out(sdo_out),
        .sdo_oe_n(sdo_oe_n), .cs_n_pin(cs_n_pin), .sck_in(sck_in),
        .sdi_pin(sdi_pin)
    );
////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [23:0] exp,
                         input logic [23:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic stop_test;
        $display("mismatches %0d, checks %0d", mismatches, check_count);
        if (mismatches == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // a hang counts as a failure, not a silent stop
    always @(posedge clk_sys) begin
        cycles++;
        if (conv_start === 1'b1) starts <= starts + 1;
        if (cycles == TIMEOUT) begin
            mismatches++;
            $display("unexpected run length: expected end, seen hang");
            stop_test();
        end
    end
////////////////////////////////////////////////////////////////////////
    initial begin
        nrst = 1'b0;
        por_done = 1'b0;
        res_valid = 1'b0;
        res_data = 22'h00_0000;
        v = 22'h2a_5c31;
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        check("reset chan_sel", 24'h00_0000, 24'(chan_sel));
        check("reset sdo_oe_n", 24'h00_0001, 24'(sdo_oe_n));
        // fill the buffer until it refuses, before conversions drain it
        res_valid <= 1'b1;
        for (i = 0; i < 8; i++) begin
            rs[i] = v;
            v = v + 22'h01_3579;
            res_data <= rs[i];
            @(posedge clk_sys);
            while (res_ready !== 1'b1) @(posedge clk_sys);
        end
        res_valid <= 1'b0;
        repeat (2) @(posedge clk_sys);
        check("full res_ready", 24'h00_0000, 24'(res_ready));
        check("idle conv_busy", 24'h00_0000, 24'(conv_busy));
        por_done <= 1'b1;
        repeat (4) @(posedge clk_sys);
        check("por mode", 24'h00_0000, 24'(int_clk_mode));
        for (i = 0; i < 5; i++) begin
            k = starts;
            u_astm_host.ext_xfer(din[i], nf[i], w);
            if (nf[i] == 24) check("word", {2'b00, rs[k - 1]}, w);
            check("starts", 24'(k + 1), 24'(starts));
            check("chan", 24'(ch[i]), 24'(chan_sel));
        end
        k = starts;
        u_astm_host.int_xfer(w);
        check("int mode", 24'h00_0001, 24'(int_clk_mode));
        check("int word", {2'b00, rs[k - 1]}, w);
        check("int starts", 24'(k + 1), 24'(starts));
        u_astm_host.deselect();
        repeat (8) @(posedge clk_sys);
        check("int chan", 24'h00_0012, 24'(chan_sel));
        k = starts;
        u_astm_host.int_peek(8);
        check("peek starts", 24'(k), 24'(starts));
        u_astm_host.int_xfer(w);
        check("last word", {2'b00, rs[k - 1]}, w);
        check("last starts", 24'(k + 1), 24'(starts));
        stop_test();
    end
endmodule
`default_nettype wire
